// ===== include/pnpc_pkg.sv
// constants for the next-page and control-one register bank
package pnpc_pkg;
    // register addresses on the management bus
    localparam logic [4:0] PNPC_ADDR_NEXT_PAGE = 5'h08;
    localparam logic [4:0] PNPC_ADDR_CONTROL_ONE = 5'h09;
    // reset values
    localparam logic [15:0] PNPC_NEXT_PAGE_RESET = 16'h0000;
    localparam logic [15:0] PNPC_CONTROL_ONE_RESET = 16'h0000;
    localparam logic [15:0] PNPC_READ_UNMAPPED = 16'h0000;
    // received next page fields
    localparam int PNPC_NP_MORE_BIT = 15;
    localparam int PNPC_NP_ACK_BIT = 14;
    localparam int PNPC_NP_MSG_BIT = 13;
    localparam int PNPC_NP_ACK2_BIT = 12;
    localparam int PNPC_NP_TOGGLE_BIT = 11;
    localparam int PNPC_NP_CODE_MSB = 10;
    localparam int PNPC_NP_CODE_LSB = 0;
    // control one fields
    localparam int PNPC_CTL_CABLE_TEST_BIT = 8;
    localparam int PNPC_CTL_CROSSOVER_BIT = 5;
    localparam int PNPC_CTL_EARLY_DV_BIT = 1;
    localparam logic [15:0] PNPC_CTL_WRITE_MASK = 16'h0122;
    // management frame layout
    localparam logic [5:0] PNPC_PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] PNPC_HEADER_LAST = 5'h0C;
    localparam logic [4:0] PNPC_DATA_LAST = 5'h0F;
    localparam logic [1:0] PNPC_OP_READ = 2'h2;
    localparam logic [1:0] PNPC_OP_WRITE = 2'h1;
    localparam int PNPC_HDR_START_BIT = 12;
    localparam int PNPC_HDR_OP_MSB = 11;
    localparam int PNPC_HDR_OP_LSB = 10;
    localparam int PNPC_HDR_PHY_MSB = 9;
    localparam int PNPC_HDR_PHY_LSB = 5;
    localparam int PNPC_HDR_REG_MSB = 4;
    localparam int PNPC_HDR_REG_LSB = 0;
endpackage

// ===== include/pnpc_if.sv
// register access carrier between the serial engine and the register bank
`timescale 1ns/10ps
`default_nettype none
interface pnpc_if;
    logic [4:0] reg_addr;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    modport serial (output reg_addr, output wr_stb, output wr_data, input rd_data);
    modport bank (input reg_addr, input wr_stb, input wr_data, output rd_data);
endinterface
`default_nettype wire

// ===== logic/pnpc_mdio.sv
// management serial engine: frame decode, read shift-out, write strobe
`timescale 1ns/10ps
`default_nettype none
module pnpc_mdio
    import pnpc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // register access
    pnpc_if.serial bus
);
    typedef enum {M_PRE, M_HDR, M_TA, M_DATA} pnpc_mstate_t;
    pnpc_mstate_t state, next_state;
    logic mdc_q, next_mdc_q;
    logic [5:0] ones, next_ones;
    logic [4:0] cnt, next_cnt;
    logic [15:0] sh, next_sh;
    logic is_read, next_is_read;
    logic [4:0] addr, next_addr;
    logic wr_stb, next_wr_stb;
    logic [15:0] wr_data, next_wr_data;
    logic out, next_out;
    logic oe_n, next_oe_n;
    logic rise;
    logic [15:0] shin;

    always_comb begin
        rise = mdc & ~mdc_q;
        shin = {sh[14:0], mdio_in};
        next_mdc_q = mdc;
        next_state = state;
        next_ones = ones;
        next_cnt = cnt;
        next_sh = sh;
        next_is_read = is_read;
        next_addr = addr;
        next_wr_stb = 1'b0;
        next_wr_data = wr_data;
        next_out = out;
        next_oe_n = oe_n;
        if (rise) begin
            unique case (state)
                M_PRE: begin
                    if (mdio_in) begin
                        if (ones < PNPC_PREAMBLE_BITS) begin
                            next_ones = ones + 6'h01;
                        end
                    end else if (ones == PNPC_PREAMBLE_BITS) begin
                        next_state = M_HDR;
                        next_cnt = 5'h00;
                        next_sh = 16'h0000;
                    end else begin
                        next_ones = 6'h00;
                    end
                end
                M_HDR: begin
                    next_sh = shin;
                    next_cnt = cnt + 5'h01;
                    if (cnt == PNPC_HEADER_LAST) begin
                        next_cnt = 5'h00;
                        next_addr = shin[PNPC_HDR_REG_MSB:PNPC_HDR_REG_LSB];
                        next_is_read = shin[PNPC_HDR_OP_MSB:PNPC_HDR_OP_LSB] == PNPC_OP_READ;
                        if (shin[PNPC_HDR_START_BIT] &&
                            shin[PNPC_HDR_PHY_MSB:PNPC_HDR_PHY_LSB] == PHY_ADDR &&
                            (shin[PNPC_HDR_OP_MSB:PNPC_HDR_OP_LSB] == PNPC_OP_READ ||
                             shin[PNPC_HDR_OP_MSB:PNPC_HDR_OP_LSB] == PNPC_OP_WRITE)) begin
                            next_state = M_TA;
                        end else begin
                            next_state = M_PRE;
                            next_ones = 6'h00;
                        end
                    end
                end
                M_TA: begin
                    if (cnt == 5'h00) begin
                        next_cnt = 5'h01;
                        next_out = 1'b0;
                        next_oe_n = ~is_read;
                    end else begin
                        next_cnt = 5'h00;
                        next_state = M_DATA;
                        next_sh = bus.rd_data;
                        next_out = bus.rd_data[15];
                    end
                end
                M_DATA: begin
                    next_cnt = cnt + 5'h01;
                    if (is_read) begin
                        next_sh = {sh[14:0], 1'b0};
                        next_out = sh[14];
                    end else begin
                        next_sh = shin;
                    end
                    if (cnt == PNPC_DATA_LAST) begin
                        next_state = M_PRE;
                        next_ones = 6'h00;
                        next_out = 1'b0;
                        next_oe_n = 1'b1;
                        next_wr_stb = ~is_read;
                        next_wr_data = shin;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= M_PRE;
            mdc_q <= 1'b0;
            ones <= 6'h00;
            cnt <= 5'h00;
            sh <= 16'h0000;
            is_read <= 1'b0;
            addr <= 5'h00;
            wr_stb <= 1'b0;
            wr_data <= 16'h0000;
            out <= 1'b0;
            oe_n <= 1'b1;
        end else begin
            state <= next_state;
            mdc_q <= next_mdc_q;
            ones <= next_ones;
            cnt <= next_cnt;
            sh <= next_sh;
            is_read <= next_is_read;
            addr <= next_addr;
            wr_stb <= next_wr_stb;
            wr_data <= next_wr_data;
            out <= next_out;
            oe_n <= next_oe_n;
        end
    end

    assign bus.reg_addr = addr;
    assign bus.wr_stb = wr_stb;
    assign bus.wr_data = wr_data;
    assign mdio_out = out;
    assign mdio_oe_n = oe_n;
endmodule
`default_nettype wire

// ===== logic/pnpc_top.sv
// register bank for the received next page and control one, with their effects
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [R1] received next page register sits at address 0x8, cleared at reset
// [R2] bit 15 shows the partner wants to send more next pages
// [R3] bit 14 shows the partner acknowledged our link code word
// [R4] bit 13 reads 1 for a message page, 0 for unformatted
// [R5] bit 12 shows the partner can comply with the message; resets 0
// [R6] toggle bit inverts the previous exchanged toggle, keeping both ends in step
// [R7] toggle reads 1 when previous transmitted toggle was 0, else 0
// [R8] bits 10..0 hold the received code, message or unformatted per bit 13
// [R9] control one sits at address 0x9, all bits reset to zero
// [R10] with bit 8 set, a cable test starts after every link drop
// [R11] with bit 8 clear, no cable test starts on link drop
// [R12] with bit 5 set, robust crossover resolution is used
// [R13] with bit 5 clear, robust crossover resolution is not used
// [R14] with bit 1 clear, receive valid rises only after the J K pair
// [R15] with bit 1 set, receive valid rises on the J symbol alone
// [R16] in early mode a J not followed by K raises receive error
// [R17] reserved control one bits read zero and ignore writes
module pnpc_top
    import pnpc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // received next page from negotiation
    input wire logic np_valid,
    input wire logic [15:0] np_word,
    // link, cable test and crossover mode
    input wire logic link_up,
    output logic cable_test_start,
    output logic crossover_robust,
    // receive symbol stream
    input wire logic sym_valid,
    input wire logic sym_is_j,
    input wire logic sym_is_k,
    input wire logic sym_is_end,
    output logic rx_dv,
    output logic rx_er
);
    typedef enum {RX_IDLE, RX_GOT_J, RX_FRAME} pnpc_rxstate_t;

    pnpc_if bus ();

    pnpc_mdio #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .clk(clk),
        .rst(rst),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n),
        .bus(bus)
    );

    // register state
    logic [15:0] partner_next_page, next_partner_next_page;
    logic [15:0] control_one, next_control_one;
    logic [15:0] rd_data;

    always_comb begin
        next_partner_next_page = partner_next_page;
        next_control_one = control_one;
        if (np_valid) begin
            next_partner_next_page = np_word; // R2 R3 R4 R5 R6 R7 R8
        end
        if (bus.wr_stb && bus.reg_addr == PNPC_ADDR_CONTROL_ONE) begin
            next_control_one = bus.wr_data & PNPC_CTL_WRITE_MASK; // R9 R17
        end
        unique case (bus.reg_addr)
            PNPC_ADDR_NEXT_PAGE: rd_data = partner_next_page; // R1
            PNPC_ADDR_CONTROL_ONE: rd_data = control_one; // R9
            default: rd_data = PNPC_READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_next_page <= PNPC_NEXT_PAGE_RESET; // R1
            control_one <= PNPC_CONTROL_ONE_RESET; // R9
        end else begin
            partner_next_page <= next_partner_next_page;
            control_one <= next_control_one;
        end
    end

    assign bus.rd_data = rd_data;

    // link drop cable test and crossover mode
    logic link_q, next_link_q;
    logic next_cable_test_start;
    logic next_crossover_robust;

    always_comb begin
        next_link_q = link_up;
        next_cable_test_start = link_q & ~link_up &
            control_one[PNPC_CTL_CABLE_TEST_BIT]; // R10 R11
        next_crossover_robust = control_one[PNPC_CTL_CROSSOVER_BIT]; // R12 R13
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_q <= 1'b0;
            cable_test_start <= 1'b0;
            crossover_robust <= 1'b0;
        end else begin
            link_q <= next_link_q;
            cable_test_start <= next_cable_test_start;
            crossover_robust <= next_crossover_robust;
        end
    end

    // start of stream detection
    pnpc_rxstate_t rx_state, next_rx_state;
    logic next_rx_dv, next_rx_er;
    logic early;

    always_comb begin
        early = control_one[PNPC_CTL_EARLY_DV_BIT];
        next_rx_state = rx_state;
        next_rx_dv = rx_dv;
        next_rx_er = 1'b0;
        if (sym_valid) begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (sym_is_j) begin
                        next_rx_state = RX_GOT_J;
                        next_rx_dv = early; // R15
                    end
                end
                RX_GOT_J: begin
                    if (sym_is_k) begin
                        next_rx_state = RX_FRAME;
                        next_rx_dv = 1'b1; // R14
                    end else begin
                        next_rx_state = RX_IDLE;
                        next_rx_dv = 1'b0;
                        next_rx_er = early; // R16
                    end
                end
                RX_FRAME: begin
                    if (sym_is_end) begin
                        next_rx_state = RX_IDLE;
                        next_rx_dv = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_dv <= next_rx_dv;
            rx_er <= next_rx_er;
        end
    end

    // checks
    chk_np_more_flag: assert property (@(posedge clk) disable iff (rst) // R2
        np_valid |=> partner_next_page[PNPC_NP_MORE_BIT] == $past(np_word[PNPC_NP_MORE_BIT]))
        else $error("next page more flag not captured");
    chk_np_ack_flag: assert property (@(posedge clk) disable iff (rst) // R3
        np_valid |=> partner_next_page[PNPC_NP_ACK_BIT] == $past(np_word[PNPC_NP_ACK_BIT]))
        else $error("next page acknowledge not captured");
    chk_np_page_hold: assert property (@(posedge clk) disable iff (rst) // R8
        !np_valid |=> partner_next_page == $past(partner_next_page))
        else $error("next page changed without a new page");
    chk_np_toggle_code: assert property (@(posedge clk) disable iff (rst) // R7
        np_valid |=> partner_next_page[PNPC_NP_TOGGLE_BIT:PNPC_NP_CODE_LSB] ==
            $past(np_word[PNPC_NP_TOGGLE_BIT:PNPC_NP_CODE_LSB]))
        else $error("toggle or code not captured");
    chk_ctl_reserved_zero: assert property (@(posedge clk) disable iff (rst) // R17
        (control_one & ~PNPC_CTL_WRITE_MASK) == 16'h0000)
        else $error("reserved control bit set");
    chk_cable_test_start: assert property (@(posedge clk) disable iff (rst) // R10
        (link_q && !link_up && control_one[PNPC_CTL_CABLE_TEST_BIT]) |=> cable_test_start ##1
        !cable_test_start)
        else $error("cable test not started once after link drop");
    chk_cable_test_quiet: assert property (@(posedge clk) disable iff (rst) // R11
        !control_one[PNPC_CTL_CABLE_TEST_BIT] |=> !cable_test_start)
        else $error("cable test started while disabled");
    chk_crossover_follow: assert property (@(posedge clk) disable iff (rst) // R12
        ##1 crossover_robust == $past(control_one[PNPC_CTL_CROSSOVER_BIT]))
        else $error("crossover mode does not follow control");
    chk_dv_after_jk: assert property (@(posedge clk) disable iff (rst) // R14
        ($rose(rx_dv) && !$past(early)) |-> $past(sym_valid && sym_is_k))
        else $error("receive valid rose without K in normal mode");
    chk_dv_early_j: assert property (@(posedge clk) disable iff (rst) // R15
        (early && rx_state == RX_IDLE && sym_valid && sym_is_j) |=> rx_dv)
        else $error("receive valid not raised on J in early mode");
    chk_er_missing_k: assert property (@(posedge clk) disable iff (rst) // R16
        (early && rx_state == RX_GOT_J && sym_valid && !sym_is_k) |=> rx_er && !rx_dv)
        else $error("missing K did not raise receive error");
endmodule
`default_nettype wire

// ===== dv/pnpc_host_model.sv
// station management host model driving the serial management pins
`timescale 1ns/10ps
`default_nettype none
module pnpc_host_model
    import pnpc_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // clock
    input wire logic clk,
    // management pins
    output var logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n
);
    logic host_oe = 1'b1;
    logic host_bit = 1'b1;
    initial mdc = 1'b0;
    // line level, pulled up when nobody drives
    assign mdio_in = host_oe ? host_bit : (!mdio_oe_n ? mdio_out : 1'b1);
    // one mdc period, sampled just before the rising edge
    task automatic bit_cycle(input logic drive, input logic b, output logic s);
        host_oe = drive;
        host_bit = b;
        repeat (3) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (4) @(negedge clk);
        mdc = 1'b0;
        @(negedge clk);
    endtask
    // whole frame: preamble, header, turnaround, data, one idle period
    task automatic frame(input logic [1:0] op, input logic [4:0] addr,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic s;
        logic wr;
        hdr = {2'b01, op, PHY_ADDR, addr};
        wr = (op == PNPC_OP_WRITE);
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
        bit_cycle(wr, 1'b1, s);
        bit_cycle(wr, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wdata[i], s);
            rdata[i] = s;
        end
        bit_cycle(1'b0, 1'b1, s);
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_pnpc_top.sv
// testbench for the next-page and control-one register bank
`timescale 1ns/10ps
`default_nettype none
module tb_pnpc_top
    import pnpc_pkg::*;
;
    logic clk, rst, mdc, mdio_in, mdio_out, mdio_oe_n;
    logic np_valid, link_up, cable_test_start, crossover_robust;
    logic sym_valid, sym_is_j, sym_is_k, sym_is_end, rx_dv, rx_er;
    logic [15:0] np_word;
    logic [15:0] pulses = 16'h0000;
    logic [15:0] pulse_base;
    int errors = 0;
    int tests_run = 0;
    localparam logic [15:0] NP_TAB [6] = '{16'h8801, 16'h4000, 16'hA805,
                                         16'h1000, 16'h2FFF, 16'h07FF};
    pnpc_top u_pnpc_top (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .np_valid(np_valid),
        .np_word(np_word), .link_up(link_up), .cable_test_start(cable_test_start),
        .crossover_robust(crossover_robust), .sym_valid(sym_valid), .sym_is_j(sym_is_j),
        .sym_is_k(sym_is_k), .sym_is_end(sym_is_end), .rx_dv(rx_dv), .rx_er(rx_er));
    pnpc_host_model u_pnpc_host_model (.clk(clk), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cable_test_start === 1'b1) pulses = pulses + 16'h0001;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        u_pnpc_host_model.frame(PNPC_OP_READ, a, 16'h0000, d);
        check(what, exp, d);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] d;
        u_pnpc_host_model.frame(PNPC_OP_WRITE, a, v, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic sym(input logic j, input logic k, input logic e);
        sym_valid = 1'b1;
        sym_is_j = j;
        sym_is_k = k;
        sym_is_end = e;
        @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        np_valid = 1'b0;
        np_word = 16'h0000;
        link_up = 1'b1;
        sym_valid = 1'b0;
        sym_is_j = 1'b0;
        sym_is_k = 1'b0;
        sym_is_end = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("idle oe_n", 16'h0001, {15'h0, mdio_oe_n});
        check("reset rx_dv", 16'h0000, {15'h0, rx_dv});
        rd(PNPC_ADDR_NEXT_PAGE, PNPC_NEXT_PAGE_RESET, "next_page reset");
        rd(PNPC_ADDR_CONTROL_ONE, PNPC_CONTROL_ONE_RESET, "control_one reset");
        rd(5'h03, PNPC_READ_UNMAPPED, "unmapped read");
        // alternating toggle bit from page to page
        for (int i = 0; i < 6; i++) begin
            np_word = NP_TAB[i];
            np_valid = 1'b1;
            @(negedge clk);
            np_valid = 1'b0;
            rd(PNPC_ADDR_NEXT_PAGE, NP_TAB[i], "next_page");
        end
        wr(PNPC_ADDR_CONTROL_ONE, 16'hFFFF);
        rd(PNPC_ADDR_CONTROL_ONE, PNPC_CTL_WRITE_MASK, "control_one mask");
        check("crossover on", 16'h0001, {15'h0, crossover_robust});
        wr(PNPC_ADDR_CONTROL_ONE, 16'h0000);
        check("crossover off", 16'h0000, {15'h0, crossover_robust});
        wr(5'h03, 16'hFFFF);
        rd(5'h03, PNPC_READ_UNMAPPED, "unmapped write");
        for (int m = 0; m < 2; m++) begin
            wr(PNPC_ADDR_CONTROL_ONE, m ? 16'h0100 : 16'h0000);
            link_up = 1'b1;
            repeat (3) @(negedge clk);
            pulse_base = pulses;
            link_up = 1'b0;
            repeat (6) @(negedge clk);
            check("cable test pulses", 16'(m), pulses - pulse_base);
        end
        for (int m = 0; m < 2; m++) begin
            wr(PNPC_ADDR_CONTROL_ONE, m ? 16'h0002 : 16'h0000);
            sym(1'b1, 1'b0, 1'b0);
            check("dv after J", 16'(m), {15'h0, rx_dv});
            sym(1'b0, 1'b1, 1'b0);
            check("dv after K", 16'h0001, {15'h0, rx_dv});
            sym(1'b0, 1'b0, 1'b1);
            check("dv after end", 16'h0000, {15'h0, rx_dv});
            sym(1'b1, 1'b0, 1'b0);
            sym(1'b0, 1'b0, 1'b0);
            check("dv after J then data", 16'h0000, {15'h0, rx_dv});
            check("er after J then data", 16'(m), {15'h0, rx_er});
            sym_valid = 1'b0;
            @(negedge clk);
            check("er pulse end", 16'h0000, {15'h0, rx_er});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
